// [logic/ctr_trap_io.sv]
// Trap vector sequencing and CPU-local I/O registers, top level
//
// Contract
// - Trap select makes the sequencer take its next address from the vector lines.
// - Each group request is the OR of its conditions, regardless of its enable.
// - Any group request raises break; trap select follows at the next permitted point.
// - With group one requesting, phase two enables only group one's vector.
// - With group two but not one requesting, phase two enables group two's vector.
// - Group three's vector is enabled only when groups one and two are idle.
// - Codes: 00 clear (three), 01 page fault (two), 02 protect, 03 ring-down (one).
// - 04 page used, 05 written in page; codes 06 to 15 never produced.
// - 16 panel interrupt and 17 macro interrupt belong to group three.
// - Control bit 13 enables the host-to-CPU interrupt, active high.
// - Control bits 10, 9, 8, 5 enable power fail, range, parity, zero interrupts.
// - Control bit 4 drives the active-low I/O bus request.
// - Control bit 3 high resets the real-time interrupt.
// - Bits 2, 1 drive active-low LEDs; bit 0 self-test LED and master clear enable.
// - The data bus is driven only for the status read decode (status) or the print status read decode (link bits).
// - Status bit 4 low means the I/O bus is granted.
// - Status bit 2 low: CPU-to-host interrupt set; bit 1 low: host-to-CPU set.
// - Status bit 3 high means the backup battery is not OK.
// - Status bits 8, 7, 6, 5: operator request, host fail, test, host present.
// - Print status read puts the 8 link bits on data bus bits 4 to 11.
`timescale 1ns/100ps
`default_nettype none
`include "ctr_defines.svh"

module ctr_trap_io (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // Trap conditions and permitted break point
  input  var ctr_pkg::ctr_trap_cond_s  trapCond,
  input  wire logic                   trapPermit,
  // Trap requests to the clock generation side
  output logic                        groupOneRequest,
  output logic                        groupTwoRequest,
  output logic                        groupThreeRequest,
  output logic                        breakRequest,
  // Trap select and vector to the microsequencer
  output logic                        trapSelect,
  output logic                        clockPhaseTwo,
  output logic                        groupOneVectorEnable,
  output logic                        groupTwoVectorEnable,
  output logic                        groupThreeVectorEnable,
  output logic      [3:0]             vectorLinesOut,
  output logic                        vectorLinesOe_b,
  // Internal data bus and microcode decodes
  input  wire logic                   loadIoControlCmd,
  input  wire logic                   readIoStatusCmd,
  input  wire logic                   readPrintStatusCmd,
  input  wire logic [15:0]            idbIn,
  output logic      [15:0]            idbOut,
  output logic                        idbOe_b,
  // Status sources and modification links
  input  var ctr_pkg::ctr_host_stat_s  hostStat,
  input  wire logic [7:0]             boardLinks,
  // Control register outputs
  output var ctr_pkg::ctr_int_enable_s intEnable,
  output logic                        hostToCpuIntReq,
  output logic                        ioBusRequest_b,
  output logic                        realtimeIntReset,
  output logic                        operatorCommunicationLed_b,
  output logic                        runLed_b,
  output logic                        selfTestLed_b,
  output logic                        masterClearEnable_b,
  output logic                        secretFlag,
  output logic                        x21Comms
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  ctr_pkg::ctr_trap_state_e state_ff;
  ctr_pkg::ctr_trap_state_e nxt_state;
  logic [1:0]  phase_ff;
  logic [2:0]  groupRequest;
  logic [2:0]  groupGrant;
  logic [3:0]  groupVector;
  logic [2:0]  vecEnable_ff;
  logic [3:0]  vector_ff;
  logic [15:0] ioControl;
  logic        captureVector;

  // ------------------------------------------------------------
  // Group requests and priority
  // ------------------------------------------------------------

  // Requests, grant and code of the winning group
  ctr_trap_prio u_prio (
    .trapCond     (trapCond),
    .groupRequest (groupRequest),
    .groupGrant   (groupGrant),
    .groupVector  (groupVector)
  );

  // Request outputs and break to clock generation
  assign groupOneRequest   = groupRequest[0];
  assign groupTwoRequest   = groupRequest[1];
  assign groupThreeRequest = groupRequest[2];
  assign breakRequest      = |groupRequest;

  // ------------------------------------------------------------
  // Microcycle phase divider
  // ------------------------------------------------------------

  // Four-phase microcycle counter, phase two is a one-cycle enable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= `CTR_PHASE_FIRST;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign clockPhaseTwo = (phase_ff == `CTR_PHASE_TWO);

  // ------------------------------------------------------------
  // Trap select sequencing
  // ------------------------------------------------------------

  // Next state: select on a permitted break, drive at phase two
  always_comb begin
    nxt_state     = state_ff;
    captureVector = 1'b0;
    case (state_ff)
      ctr_pkg::ST_IDLE: begin
        if (breakRequest && trapPermit) begin
          nxt_state = ctr_pkg::ST_SELECT;
        end
      end
      ctr_pkg::ST_SELECT: begin
        if (clockPhaseTwo) begin
          if (breakRequest) begin
            nxt_state     = ctr_pkg::ST_DRIVE;
            captureVector = 1'b1;
          end else begin
            nxt_state = ctr_pkg::ST_IDLE;                     // Request withdrawn before phase two
          end
        end
      end
      ctr_pkg::ST_DRIVE: begin
        nxt_state = ctr_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = ctr_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ctr_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Trap select spans selection and the capture cycle
  assign trapSelect = (state_ff == ctr_pkg::ST_SELECT) || (state_ff == ctr_pkg::ST_DRIVE);

  // Vector enables held for the capture cycle only, code kept until the next capture
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vecEnable_ff <= 3'h0;
      vector_ff    <= `CTR_VEC_MASTER_CLEAR;
    end else if (captureVector) begin
      vecEnable_ff <= groupGrant;
      vector_ff    <= groupVector;
    end else begin
      vecEnable_ff <= 3'h0;
    end
  end

  // Vector line drive toward the microsequencer
  assign groupOneVectorEnable   = vecEnable_ff[0];
  assign groupTwoVectorEnable   = vecEnable_ff[1];
  assign groupThreeVectorEnable = vecEnable_ff[2];
  assign vectorLinesOut         = vector_ff;
  assign vectorLinesOe_b        = ~|vecEnable_ff;

  // ------------------------------------------------------------
  // CPU I/O registers
  // ------------------------------------------------------------

  // Control load, status and print status reads
  ctr_io_regs u_io (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .loadIoControlCmd   (loadIoControlCmd),
    .readIoStatusCmd    (readIoStatusCmd),
    .readPrintStatusCmd (readPrintStatusCmd),
    .idbIn              (idbIn),
    .idbOut             (idbOut),
    .idbOe_b            (idbOe_b),
    .hostStat           (hostStat),
    .boardLinks         (boardLinks),
    .ioControl          (ioControl)
  );

  // Interrupt enables from the control register
  assign intEnable.hostToCpu = ioControl[`CTR_CTL_HOST_INT_EN];
  assign intEnable.powerFail = ioControl[`CTR_CTL_POWER_FAIL_EN];
  assign intEnable.memRange  = ioControl[`CTR_CTL_MEM_RANGE_EN];
  assign intEnable.parity    = ioControl[`CTR_CTL_PARITY_EN];
  assign intEnable.zero      = ioControl[`CTR_CTL_ZERO_EN];

  // Host-to-CPU interrupt gated by its enable
  assign hostToCpuIntReq = ioControl[`CTR_CTL_HOST_INT_EN] & hostStat.hostToCpuIntFlag;

  // Bus request, real-time reset and indicator drives
  assign ioBusRequest_b             = ioControl[`CTR_CTL_BUS_REQ];
  assign realtimeIntReset           = ioControl[`CTR_CTL_RT_RESET];
  assign operatorCommunicationLed_b = ioControl[`CTR_CTL_OPERATOR_COMMUNICATION_LED];
  assign runLed_b                   = ioControl[`CTR_CTL_RUN_LED];
  assign selfTestLed_b              = ioControl[`CTR_CTL_SELF_TEST];
  assign masterClearEnable_b        = ioControl[`CTR_CTL_SELF_TEST];
  assign secretFlag                 = ioControl[15];
  assign x21Comms                   = ioControl[14];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  group_req_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    groupTwoRequest == (trapCond.pageFault | trapCond.pageUsed | trapCond.writtenInPage)
    && groupOneRequest == (trapCond.protectViolation | trapCond.ringDown))
    else $error("group request not the OR of its conditions");

  break_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!trapSelect && breakRequest && trapPermit) |=> trapSelect)
    else $error("trap select did not follow a permitted break");

  sel_to_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(trapSelect) |-> ##[1:4] (clockPhaseTwo || !trapSelect))
    else $error("trap selection waited past phase two");

  g1_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ctr_pkg::ST_SELECT && clockPhaseTwo && groupOneRequest)
    |=> groupOneVectorEnable && !groupTwoVectorEnable && !groupThreeVectorEnable)
    else $error("group one did not win at phase two");

  g2_second_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ctr_pkg::ST_SELECT && clockPhaseTwo && groupTwoRequest && !groupOneRequest)
    |=> groupTwoVectorEnable && !groupOneVectorEnable && !groupThreeVectorEnable)
    else $error("group two not chosen");

  g3_last_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(groupThreeVectorEnable) |-> $past(groupThreeRequest && !groupOneRequest && !groupTwoRequest))
    else $error("group three enabled while a higher group requested");

  g1_codes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    groupOneVectorEnable |-> (vectorLinesOut == `CTR_VEC_PROTECT || vectorLinesOut == `CTR_VEC_RING_DOWN))
    else $error("group one drove a foreign code");

  no_spare_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !vectorLinesOe_b |-> !(vectorLinesOut >= `CTR_VEC_SPARE_LO && vectorLinesOut <= `CTR_VEC_SPARE_HI))
    else $error("spare vector driven");

  g3_codes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    groupThreeVectorEnable |-> (vectorLinesOut == `CTR_VEC_MASTER_CLEAR
    || vectorLinesOut == `CTR_VEC_PANEL_INT || vectorLinesOut == `CTR_VEC_MACRO_INT))
    else $error("group three drove a foreign code");

  one_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !vectorLinesOe_b |-> trapSelect ##1 vectorLinesOe_b)
    else $error("vector lines held beyond the capture cycle");

  led_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd |=> selfTestLed_b == $past(idbIn[0]) && masterClearEnable_b == $past(idbIn[0]))
    else $error("self-test drive not from control bit 0");

  phase_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clockPhaseTwo |=> !clockPhaseTwo ##1 !clockPhaseTwo ##1 !clockPhaseTwo ##1 clockPhaseTwo)
    else $error("phase two not a one-cycle pulse every four clocks");

  sel_withdraw_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_ff == ctr_pkg::ST_SELECT && clockPhaseTwo && !breakRequest) |=> !trapSelect && vectorLinesOe_b)
    else $error("withdrawn break still drove a vector");

  int_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd |=> intEnable == {$past(idbIn[13]), $past(idbIn[10:8]), $past(idbIn[5])})
    else $error("interrupt enables not from control bits 13, 10 to 8 and 5");

  rt_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd |=> realtimeIntReset == $past(idbIn[3]))
    else $error("real-time reset not from control bit 3");

  ind_led_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd |=> {operatorCommunicationLed_b, runLed_b} == $past(idbIn[2:1]))
    else $error("indicator drives not from control bits 2 and 1");

  trap_g1_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    breakRequest && trapPermit && !trapSelect ##[1:6] groupOneVectorEnable);
  trap_g3_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    groupThreeVectorEnable && vectorLinesOut == `CTR_VEC_MACRO_INT);
  ctl_load_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd ##1 !ioBusRequest_b);
  sel_withdraw_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_ff == ctr_pkg::ST_SELECT && clockPhaseTwo && !breakRequest);

endmodule
`default_nettype wire

// [logic/ctr_defines.svh]
// Field positions, reset values and vector codes of the trap and CPU I/O register block
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH

// ------------------------------------------------------------
// Trap vector codes on the four vector lines
// ------------------------------------------------------------
`define CTR_VEC_MASTER_CLEAR  4'h0
`define CTR_VEC_PAGE_FAULT    4'h1
`define CTR_VEC_PROTECT       4'h2
`define CTR_VEC_RING_DOWN     4'h3
`define CTR_VEC_PAGE_USED     4'h4
`define CTR_VEC_WRITTEN_PAGE  4'h5
`define CTR_VEC_SPARE_LO      4'h6
`define CTR_VEC_SPARE_HI      4'hD
`define CTR_VEC_PANEL_INT     4'hE
`define CTR_VEC_MACRO_INT     4'hF

// ------------------------------------------------------------
// Microcycle phases
// ------------------------------------------------------------
`define CTR_PHASE_FIRST       2'h0
`define CTR_PHASE_TWO         2'h2

// ------------------------------------------------------------
// I/O control register fields and reset value
// ------------------------------------------------------------
`define CTR_CTL_HOST_INT_EN   13
`define CTR_CTL_POWER_FAIL_EN 10
`define CTR_CTL_MEM_RANGE_EN  9
`define CTR_CTL_PARITY_EN     8
`define CTR_CTL_ZERO_EN       5
`define CTR_CTL_BUS_REQ       4
`define CTR_CTL_RT_RESET      3
`define CTR_CTL_OPERATOR_COMMUNICATION_LED     2
`define CTR_CTL_RUN_LED       1
`define CTR_CTL_SELF_TEST     0
`define CTR_CTL_RESET         16'h0017

// ------------------------------------------------------------
// Print status field on the internal data bus
// ------------------------------------------------------------
`define CTR_PRINT_LSB         4
`define CTR_STATUS_WIDTH      10

`endif

// [logic/ctr_pkg.sv]
// Types shared by the trap and CPU I/O register block
package ctr_pkg;

  // Trap sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SELECT = 3'b010,
    ST_DRIVE  = 3'b100
  } ctr_trap_state_e;

  // Trap conditions, each active high
  typedef struct packed {
    logic protectViolation;
    logic ringDown;
    logic pageFault;
    logic pageUsed;
    logic writtenInPage;
    logic masterClear;
    logic panelInt;
    logic macroInt;
  } ctr_trap_cond_s;

  // Status sources, each active high in meaning
  typedef struct packed {
    logic opcomRequest;
    logic hostPowerFail;
    logic consoleTest;
    logic hostPresent;
    logic ioBusGrant;
    logic batteryFault;
    logic cpuToHostIntFlag;
    logic hostToCpuIntFlag;
  } ctr_host_stat_s;

  // Interrupt enables from the I/O control register
  typedef struct packed {
    logic hostToCpu;
    logic powerFail;
    logic memRange;
    logic parity;
    logic zero;
  } ctr_int_enable_s;

endpackage

// [logic/ctr_trap_prio.sv]
// Trap group requests, group priority and vector encoding
`timescale 1ns/100ps
`default_nettype none
`include "ctr_defines.svh"

module ctr_trap_prio (
  // Trap conditions
  input  var ctr_pkg::ctr_trap_cond_s trapCond,
  // Group requests and chosen group
  output logic [2:0]                  groupRequest,
  output logic [2:0]                  groupGrant,
  output logic [3:0]                  groupVector
);

  // Highest group wins: group one over two over three
  function automatic logic [2:0] prio_grant(input logic [2:0] req);
    prio_grant = req[0] ? 3'h1 : (req[1] ? 3'h2 : (req[2] ? 3'h4 : 3'h0));
  endfunction

  // Vector of the granted group, fixed order inside each group
  function automatic logic [3:0] vec_encode(input logic [2:0] grant, input ctr_pkg::ctr_trap_cond_s c);
    vec_encode = `CTR_VEC_MASTER_CLEAR;
    if (grant[0]) begin
      vec_encode = c.protectViolation ? `CTR_VEC_PROTECT : `CTR_VEC_RING_DOWN;
    end else if (grant[1]) begin
      vec_encode = c.pageFault ? `CTR_VEC_PAGE_FAULT :
                   (c.pageUsed ? `CTR_VEC_PAGE_USED : `CTR_VEC_WRITTEN_PAGE);
    end else if (grant[2]) begin
      vec_encode = c.masterClear ? `CTR_VEC_MASTER_CLEAR :
                   (c.panelInt ? `CTR_VEC_PANEL_INT : `CTR_VEC_MACRO_INT);
    end
  endfunction

  // Requests do not depend on any vector enable
  assign groupRequest[0] = trapCond.protectViolation | trapCond.ringDown;
  assign groupRequest[1] = trapCond.pageFault | trapCond.pageUsed | trapCond.writtenInPage;
  assign groupRequest[2] = trapCond.masterClear | trapCond.panelInt | trapCond.macroInt;

  // Priority and code
  assign groupGrant  = prio_grant(groupRequest);
  assign groupVector = vec_encode(groupGrant, trapCond);

endmodule
`default_nettype wire

// [logic/ctr_io_regs.sv]
// I/O control register, I/O status register and print status read path
`timescale 1ns/100ps
`default_nettype none
`include "ctr_defines.svh"

module ctr_io_regs (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Microcode decodes
  input  wire logic                  loadIoControlCmd,
  input  wire logic                  readIoStatusCmd,
  input  wire logic                  readPrintStatusCmd,
  // Internal data bus
  input  wire logic [15:0]           idbIn,
  output logic      [15:0]           idbOut,
  output logic                       idbOe_b,
  // Status sources
  input  var ctr_pkg::ctr_host_stat_s hostStat,
  input  wire logic [7:0]            boardLinks,
  // Control register contents
  output logic      [15:0]           ioControl
);

  logic [15:0] ioControl_ff;
  logic [15:0] idbOut_ff;
  logic        idbOe_b_ff;
  logic [15:0] nxt_idbOut;

  // Status word, active-low bits inverted here
  function automatic logic [15:0] status_word(input ctr_pkg::ctr_host_stat_s s);
    status_word = {6'h00, 1'b0, ~s.opcomRequest, s.hostPowerFail, ~s.consoleTest, ~s.hostPresent,
                   ~s.ioBusGrant, s.batteryFault, ~s.cpuToHostIntFlag, ~s.hostToCpuIntFlag, 1'b0};
  endfunction

  // Control register load from the data bus
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ioControl_ff <= `CTR_CTL_RESET;
    end else if (loadIoControlCmd) begin
      ioControl_ff <= idbIn;
    end
  end

  // Read data selection, status over print status
  always_comb begin
    nxt_idbOut = 16'h0000;
    if (readIoStatusCmd) begin
      nxt_idbOut = status_word(hostStat);
    end else if (readPrintStatusCmd) begin
      nxt_idbOut = {4'h0, boardLinks, 4'h0};
    end
  end

  // Registered bus drive, one cycle per decode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idbOut_ff  <= 16'h0000;
      idbOe_b_ff <= 1'b1;
    end else begin
      idbOut_ff  <= nxt_idbOut;
      idbOe_b_ff <= ~(readIoStatusCmd | readPrintStatusCmd);
    end
  end

  assign ioControl = ioControl_ff;
  assign idbOut    = idbOut_ff;
  assign idbOe_b   = idbOe_b_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  ctl_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loadIoControlCmd |=> ioControl[`CTR_CTL_BUS_REQ] == $past(idbIn[`CTR_CTL_BUS_REQ]))
    else $error("control register did not load bus request bit");
  stat_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    readIoStatusCmd |=> !idbOe_b && idbOut[1] == !$past(hostStat.hostToCpuIntFlag) && idbOut[15:10] == 6'h00)
    else $error("status read word wrong");
  print_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (readPrintStatusCmd && !readIoStatusCmd) |=> !idbOe_b && idbOut[11:4] == $past(boardLinks))
    else $error("print status not on bits 4 to 11");
  bus_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(readIoStatusCmd || readPrintStatusCmd) |=> idbOe_b)
    else $error("data bus driven without a read decode");
  stat_read_c: cover property (@(posedge ref_clk) disable iff (!rst_b) readIoStatusCmd ##1 !idbOe_b);

endmodule
`default_nettype wire

// [dv/ctr_seq_model.sv]
// Microsequencer model that captures trap vectors
`timescale 1ns/100ps
`default_nettype none
module ctr_seq_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Vector path from the device
  input  wire logic       trapSelect,
  input  wire logic       vectorLinesOe_b,
  input  wire logic [3:0] vectorLinesOut,
  // Captured results
  output logic      [3:0] capVec,
  output logic      [7:0] capCount
);
  // Next address taken from the vector lines while trap select is high and the lines are driven
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      capVec   <= 4'h0;
      capCount <= 8'h00;
    end else if (trapSelect && !vectorLinesOe_b) begin
      capVec   <= vectorLinesOut;
      capCount <= capCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the trap and CPU I/O register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk, rst_b, trapPermit, loadIoControlCmd, readIoStatusCmd, readPrintStatusCmd;
  logic groupOneRequest, groupTwoRequest, groupThreeRequest, breakRequest, trapSelect, clockPhaseTwo;
  logic groupOneVectorEnable, groupTwoVectorEnable, groupThreeVectorEnable, vectorLinesOe_b, idbOe_b;
  logic hostToCpuIntReq, ioBusRequest_b, realtimeIntReset, operatorCommunicationLed_b, runLed_b;
  logic selfTestLed_b, masterClearEnable_b, secretFlag, x21Comms;
  ctr_pkg::ctr_trap_cond_s  trapCond;
  ctr_pkg::ctr_host_stat_s  hostStat;
  ctr_pkg::ctr_int_enable_s intEnable;
  logic [15:0] idbIn, idbOut;
  logic [7:0]  boardLinks, capCount;
  logic [3:0]  vectorLinesOut, capVec;
  integer      seed = 44031, badCount = 0, nCompared = 0, nTraps = 0, i, k;

  ctr_trap_io u_dut (.ref_clk, .rst_b, .trapCond, .trapPermit, .groupOneRequest, .groupTwoRequest,
    .groupThreeRequest, .breakRequest, .trapSelect, .clockPhaseTwo, .groupOneVectorEnable,
    .groupTwoVectorEnable, .groupThreeVectorEnable, .vectorLinesOut, .vectorLinesOe_b, .loadIoControlCmd,
    .readIoStatusCmd, .readPrintStatusCmd, .idbIn, .idbOut, .idbOe_b, .hostStat, .boardLinks, .intEnable,
    .hostToCpuIntReq, .ioBusRequest_b, .realtimeIntReset, .operatorCommunicationLed_b, .runLed_b,
    .selfTestLed_b, .masterClearEnable_b, .secretFlag, .x21Comms);
  ctr_seq_model u_seq (.ref_clk, .rst_b, .trapSelect, .vectorLinesOe_b, .vectorLinesOut, .capVec, .capCount);

  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    badCount++;
    conclude();
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Expected vector: group one, then two, then three
  function automatic logic [3:0] expVec(input logic [7:0] c);
    casez (c)
      8'b1???????: return 4'h2;
      8'b01??????: return 4'h3;
      8'b001?????: return 4'h1;
      8'b0001????: return 4'h4;
      8'b00001???: return 4'h5;
      8'b000001??: return 4'h0;
      8'b0000001?: return 4'hE;
      default:     return 4'hF;
    endcase
  endfunction
  function automatic logic [15:0] expStat(input ctr_pkg::ctr_host_stat_s h);
    return {7'h00, ~h.opcomRequest, h.hostPowerFail, ~h.consoleTest, ~h.hostPresent, ~h.ioBusGrant,
            h.batteryFault, ~h.cpuToHostIntFlag, ~h.hostToCpuIntFlag, 1'b0};
  endfunction
  task automatic trap(input logic [7:0] c);
    logic [2:0] r;
    logic       ph;
    r = {|c[7:6], |c[5:3], |c[2:0]};
    trapCond = c;
    trapPermit = 1'b0;
    #1 chk({groupOneRequest, groupTwoRequest, groupThreeRequest, breakRequest}, {r, |r});
    @(negedge ref_clk);
    chk(trapSelect, 1'b0);
    trapPermit = 1'b1;
    ph = 1'b0;
    for (k = 0; k < 12 && vectorLinesOe_b !== 1'b0; k++) begin
      ph = clockPhaseTwo;
      @(negedge ref_clk);
    end
    chk({ph, trapSelect, groupOneVectorEnable, groupTwoVectorEnable, groupThreeVectorEnable, vectorLinesOut},
        {2'b11, r[2], r[2:1] == 2'b01, r == 3'b001, expVec(c)});
    trapCond = '0;
    @(negedge ref_clk);
    chk({capVec, vectorLinesOe_b, groupOneVectorEnable, groupTwoVectorEnable, groupThreeVectorEnable},
        {expVec(c), 4'b1000});
    for (k = 0; k < 6 && trapSelect !== 1'b0; k++) @(negedge ref_clk);
    nTraps++;
  endtask
  // Break taken, then withdrawn before phase two: no vector may follow
  task automatic withdraw(input logic [7:0] c);
    trapCond = c;
    @(negedge ref_clk);
    chk(trapSelect, 1'b1);
    trapCond = '0;
    for (k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      chk(vectorLinesOe_b, 1'b1);
    end
    chk(trapSelect, 1'b0);
  endtask
  task automatic chkCtl(input logic [15:0] d);
    chk({secretFlag, x21Comms, intEnable, hostToCpuIntReq, ioBusRequest_b, realtimeIntReset,
         operatorCommunicationLed_b, runLed_b, selfTestLed_b, masterClearEnable_b},
        {d[15:13], d[10:8], d[5], d[13] & hostStat.hostToCpuIntFlag, d[4:0], d[0]});
  endtask
  task automatic rd(input logic s, input logic p, input logic [15:0] e);
    readIoStatusCmd = s;
    readPrintStatusCmd = p;
    @(negedge ref_clk);
    {readIoStatusCmd, readPrintStatusCmd} = 2'b00;
    chk({idbOe_b, idbOut[15:1]}, {1'b0, e[15:1]});
    @(negedge ref_clk);
    chk(idbOe_b, 1'b1);
  endtask

  // Main sequence: reset, then trap, control and read traffic
  initial begin
    {rst_b, loadIoControlCmd, readIoStatusCmd, readPrintStatusCmd} = 4'h0;
    {trapCond, hostStat, boardLinks, idbIn} = '0;
    trapPermit = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    chkCtl(16'h0017);
    for (i = 0; i < 40; i++) begin
      trap(i < 8 ? 8'h01 << i : (i == 8 ? 8'hFF : 8'($random(seed)) | 8'h01));
      idbIn = 16'($random(seed));
      hostStat = 8'($random(seed));
      boardLinks = 8'($random(seed));
      loadIoControlCmd = 1'b1;
      @(negedge ref_clk);
      loadIoControlCmd = 1'b0;
      chkCtl(idbIn);
      rd(1'b1, 1'b0, expStat(hostStat));
      rd(1'b0, 1'b1, {4'h0, boardLinks, 4'h0});
      rd(1'b1, 1'b1, expStat(hostStat));
      if (i > 8) withdraw(8'($random(seed)) | 8'h01);
      $display("test %0d done", i);
    end
    chk(capCount, 16'(nTraps));
    conclude();
  end
endmodule
`default_nettype wire
